// File: hdl/pmoc_top.sv
// power mode control, core clock divider and low-power oscillator calibration
// assumes an APB master on clk_sys and oscillator ticks synchronous to clk_sys
`timescale 1ns/1ps
`include "pmoc_params.svh"

// Notes on behaviour
// - precision oscillator input enabled only when its bit and high-voltage enable are set
// - crystal circuitry runs while its power bit is one, else powered down
// - PLL powers down only if PLL, peripheral and core bits clear together
// - peripherals power down only if peripheral and core bits clear together
// - PLL, peripheral and core bits reset to one and are set on wake-up
// - LIN wake detection and low-power-clocked wake-up timer keep running
// - peripheral bit gates SRAM, flash, GPIO, SPI and UART
// - PLL-clocked timers stop with the PLL; oscillator-clocked timers continue
// - core bit clear removes core clock until a wake-up event
// - core clock is PLL rate divided by two to the divider field, field values above six taken as six
// - nine-bit reference counter counts precision or crystal ticks by source bit
// - ten-bit counter counts low-power ticks directly or divided by four
// - four trim bits; larger value slows the low-power oscillator
// - both counters stop and hold when reference counter reaches all ones
// - source bit one selects crystal, zero the precision oscillator
// - reset bit clears both counters and disables calibration
// - bit two clears low-power counter, bit one clears reference counter
// - enable bit starts a run; clearing it mid-run aborts
// - a run lasts about 4 ms on precision source, 16 ms on crystal
// - status gives two-bit run state and an in-progress flag
// - power register write needs prewrite key before and postwrite key after
module pmoc_top #(
  parameter int REF_W = 9,
  parameter int LP_W = 10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_event,
  input wire logic hv_prec_osc_en,
  input wire logic wut_on_lp_osc,
  input wire pmoc_pkg::pmoc_osc_s osc_in,
  output pmoc_pkg::pmoc_pwr_s pwr_out,
  output logic core_clk_tick,
  output logic [3:0] lp_osc_trim
);
  import pmoc_pkg::*;

  if (REF_W < 2 || LP_W <= REF_W || REF_W > 16 || LP_W > 16) begin : g_chk
    $error("pmoc_top: counter widths not supported");
  end

  logic [7:0] power_control_r;
  logic [7:0] power_pending_r;
  logic [3:0] trim_r;
  logic cal_src_r;
  logic cal_en_r;
  pmoc_key_e key_r;
  pmoc_cal_e cal_r;
  logic [REF_W-1:0] ref_cnt_r;
  logic [LP_W-1:0] lp_cnt_r;
  logic [1:0] lp_div_r;
  logic [`PMOC_CD_CNT_W-1:0] cd_cnt_r;
  logic [31:0] prdata_r;
  logic core_tick_r;
  pmoc_pwr_s pwr_r;

  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic wr_key0;
  logic wr_key1;
  logic wr_pow;
  logic wr_cal;
  logic [7:0] pow_fix;
  logic ref_tick;
  logic lp_tick;
  logic cal_start;
  logic cal_abort;
  logic ref_full;
  logic [1:0] sta_code;
  logic [2:0] cd_eff;
  logic [`PMOC_CD_CNT_W-1:0] cd_mask;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == `PMOC_A_KEY0) | (paddr == `PMOC_A_POWER) |
                  (paddr == `PMOC_A_KEY1) | (paddr == `PMOC_A_TRIM) |
                  (paddr == `PMOC_A_CALCTL) | (paddr == `PMOC_A_CALSTA) |
                  (paddr == `PMOC_A_REFCNT) | (paddr == `PMOC_A_LPCNT);
  assign pslverr = access & ~mapped;
  assign prdata = prdata_r;

  assign wr_key0 = wr & (paddr == `PMOC_A_KEY0);
  assign wr_pow = wr & (paddr == `PMOC_A_POWER);
  assign wr_key1 = wr & (paddr == `PMOC_A_KEY1);
  assign wr_cal = wr & (paddr == `PMOC_A_CALCTL);

  // enforce power-down ordering on the stored value
  always_comb begin
    pow_fix = power_pending_r;
    pow_fix[`PMOC_P_PER] = power_pending_r[`PMOC_P_PER] | power_pending_r[`PMOC_P_CORE];
    pow_fix[`PMOC_P_PLL] = power_pending_r[`PMOC_P_PLL] | power_pending_r[`PMOC_P_PER] |
                           power_pending_r[`PMOC_P_CORE];
  end

  // key sequence: prewrite key, value, postwrite key; any other write breaks it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      key_r <= PMOC_KEY_NONE;
      power_pending_r <= `PMOC_PWR_RST;
    end else if (wr) begin
      unique case (key_r)
        PMOC_KEY_NONE: key_r <= (wr_key0 && pwdata == `PMOC_KEY0_VAL) ? PMOC_KEY_PRE : PMOC_KEY_NONE;
        PMOC_KEY_PRE: begin
          if (wr_pow) begin
            key_r <= PMOC_KEY_VAL;
            power_pending_r <= pwdata[7:0];
          end else begin
            key_r <= (wr_key0 && pwdata == `PMOC_KEY0_VAL) ? PMOC_KEY_PRE : PMOC_KEY_NONE;
          end
        end
        PMOC_KEY_VAL: key_r <= PMOC_KEY_NONE;
        default: key_r <= PMOC_KEY_NONE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      power_control_r <= `PMOC_PWR_RST;
    end else begin
      if (wr_key1 && key_r == PMOC_KEY_VAL && pwdata == `PMOC_KEY1_VAL) begin
        power_control_r <= pow_fix;
      end
      if (wake_event) begin
        power_control_r[`PMOC_P_PLL] <= 1'b1;
        power_control_r[`PMOC_P_PER] <= 1'b1;
        power_control_r[`PMOC_P_CORE] <= 1'b1;
      end
    end
  end

  // power and clock enables toward the rest of the chip
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pwr_r <= '0;
    end else begin
      pwr_r.prec_osc_en <= power_control_r[`PMOC_P_PREC] & hv_prec_osc_en;
      pwr_r.xtal_en <= power_control_r[`PMOC_P_XTAL];
      pwr_r.pll_en <= power_control_r[`PMOC_P_PLL];
      pwr_r.periph_en <= power_control_r[`PMOC_P_PER];
      pwr_r.core_en <= power_control_r[`PMOC_P_CORE];
      pwr_r.pll_timer_en <= power_control_r[`PMOC_P_PLL];
      pwr_r.wut_en <= power_control_r[`PMOC_P_PER] | wut_on_lp_osc;
      pwr_r.lin_wake_en <= 1'b1;
    end
  end
  assign pwr_out = pwr_r;

  // core clock enable: one pulse every two to the divider field cycles, field capped at six
  assign cd_eff = (power_control_r[`PMOC_P_CD_HI:`PMOC_P_CD_LO] > `PMOC_CD_MAX) ?
                  `PMOC_CD_MAX : power_control_r[`PMOC_P_CD_HI:`PMOC_P_CD_LO];
  assign cd_mask = `PMOC_CD_CNT_W'((7'h01 << cd_eff) - 7'h01);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cd_cnt_r <= '0;
      core_tick_r <= 1'b0;
    end else begin
      cd_cnt_r <= cd_cnt_r + `PMOC_CD_CNT_W'(1);
      core_tick_r <= power_control_r[`PMOC_P_CORE] &
                     ((cd_cnt_r & cd_mask) == cd_mask);
    end
  end
  assign core_clk_tick = core_tick_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trim_r <= `PMOC_TRIM_RST;
    end else if (wr && paddr == `PMOC_A_TRIM) begin
      trim_r <= pwdata[`PMOC_TRIM_W-1:0];
    end
  end
  assign lp_osc_trim = trim_r;

  // calibration control
  assign cal_start = wr_cal & pwdata[`PMOC_C_EN] & ~pwdata[`PMOC_C_RST] & ~cal_en_r;
  assign cal_abort = wr_cal & (~pwdata[`PMOC_C_EN] | pwdata[`PMOC_C_RST]);
  assign ref_full = (ref_cnt_r == {REF_W{1'b1}});

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cal_src_r <= 1'b0;
      cal_en_r <= 1'b0;
    end else begin
      if (wr_cal) begin
        cal_src_r <= pwdata[`PMOC_C_SRC];
        cal_en_r <= pwdata[`PMOC_C_EN] & ~pwdata[`PMOC_C_RST];
      end else if (cal_r == PMOC_DONE) begin
        cal_en_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cal_r <= PMOC_IDLE;
    end else if (cal_abort) begin
      cal_r <= PMOC_IDLE;
    end else begin
      unique case (cal_r)
        PMOC_IDLE: cal_r <= cal_start ? PMOC_ARM : PMOC_IDLE;
        PMOC_ARM: cal_r <= PMOC_COUNT;
        PMOC_COUNT: cal_r <= ref_full ? PMOC_DONE : PMOC_COUNT;
        PMOC_DONE: cal_r <= PMOC_IDLE;
        default: cal_r <= PMOC_IDLE;
      endcase
    end
  end

  // tick selection: low-power ticks divided by four when the crystal is the reference
  assign ref_tick = cal_src_r ? osc_in.xtal_tick : osc_in.prec_tick;
  assign lp_tick = osc_in.lp_tick & (~cal_src_r | (lp_div_r == `PMOC_LP_DIV_END));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lp_div_r <= '0;
    end else if (cal_r != PMOC_COUNT) begin
      lp_div_r <= '0;
    end else if (osc_in.lp_tick) begin
      lp_div_r <= lp_div_r + 2'h1;
    end
  end

  // counters run for 511 reference ticks, about 4 ms or 16 ms
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_cnt_r <= '0;
    end else if (wr_cal && (pwdata[`PMOC_C_RST] || pwdata[`PMOC_C_CLRREF])) begin
      ref_cnt_r <= '0;
    end else if (cal_r == PMOC_ARM) begin
      ref_cnt_r <= '0;
    end else if (cal_r == PMOC_COUNT && !ref_full && ref_tick) begin
      ref_cnt_r <= ref_cnt_r + REF_W'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lp_cnt_r <= '0;
    end else if (wr_cal && (pwdata[`PMOC_C_RST] || pwdata[`PMOC_C_CLRLP])) begin
      lp_cnt_r <= '0;
    end else if (cal_r == PMOC_ARM) begin
      lp_cnt_r <= '0;
    end else if (cal_r == PMOC_COUNT && !ref_full && lp_tick) begin
      lp_cnt_r <= lp_cnt_r + LP_W'(1);
    end
  end

  // status code from the state
  always_comb begin
    unique case (cal_r)
      PMOC_IDLE: sta_code = 2'h0;
      PMOC_ARM: sta_code = 2'h1;
      PMOC_COUNT: sta_code = 2'h2;
      PMOC_DONE: sta_code = 2'h3;
      default: sta_code = 2'h0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata_r <= '0;
    end else if (setup) begin
      prdata_r <= '0;
      unique case (paddr)
        `PMOC_A_POWER: prdata_r[7:0] <= power_control_r;
        `PMOC_A_TRIM: prdata_r[`PMOC_TRIM_W-1:0] <= trim_r;
        `PMOC_A_CALCTL: begin
          prdata_r[`PMOC_C_SRC] <= cal_src_r;
          prdata_r[`PMOC_C_EN] <= cal_en_r;
        end
        `PMOC_A_CALSTA: prdata_r[3:0] <= {sta_code, cal_en_r, cal_r != PMOC_IDLE};
        `PMOC_A_REFCNT: prdata_r[REF_W-1:0] <= ref_cnt_r;
        `PMOC_A_LPCNT: prdata_r[LP_W-1:0] <= lp_cnt_r;
        default: prdata_r <= '0;
      endcase
    end
  end
endmodule : pmoc_top

// File: hdl/pmoc_params.svh
// register addresses, field positions, keys and reset values of the power/calibration block
// assumes inclusion by bare name from the top module, the checker and the bench
`ifndef PMOC_PARAMS_SVH
`define PMOC_PARAMS_SVH
`define PMOC_A_KEY0 32'hFFFF0404
`define PMOC_A_POWER 32'hFFFF0408
`define PMOC_A_KEY1 32'hFFFF040C
`define PMOC_A_TRIM 32'hFFFF042C
`define PMOC_A_CALCTL 32'hFFFF0440
`define PMOC_A_CALSTA 32'hFFFF0444
`define PMOC_A_REFCNT 32'hFFFF0448
`define PMOC_A_LPCNT 32'hFFFF044C
`define PMOC_KEY0_VAL 32'h00000001
`define PMOC_KEY1_VAL 32'h000000F4
`define PMOC_PWR_RST 8'h79
`define PMOC_TRIM_RST 4'h8
`define PMOC_CAL_RST 8'h00
`define PMOC_P_XTAL 7
`define PMOC_P_PREC 6
`define PMOC_P_PLL 5
`define PMOC_P_PER 4
`define PMOC_P_CORE 3
`define PMOC_P_CD_HI 2
`define PMOC_P_CD_LO 0
`define PMOC_C_SRC 4
`define PMOC_C_RST 3
`define PMOC_C_CLRLP 2
`define PMOC_C_CLRREF 1
`define PMOC_C_EN 0
`define PMOC_CD_MAX 3'h6
`define PMOC_CD_CNT_W 6
`define PMOC_LP_DIV_END 2'h3
`define PMOC_TRIM_W 4
`endif

// File: hdl/pmoc_pkg.sv
// types shared by the power mode and oscillator calibration block
// assumes pmoc_params.svh is on the include path
package pmoc_pkg;
  typedef enum logic [1:0] {
    PMOC_IDLE = 2'h0,
    PMOC_ARM = 2'h1,
    PMOC_COUNT = 2'h3,
    PMOC_DONE = 2'h2
  } pmoc_cal_e;

  typedef enum logic [1:0] {
    PMOC_KEY_NONE = 2'h0,
    PMOC_KEY_PRE = 2'h1,
    PMOC_KEY_VAL = 2'h3
  } pmoc_key_e;

  typedef struct packed {
    logic prec_osc_en;
    logic xtal_en;
    logic pll_en;
    logic periph_en;
    logic core_en;
    logic pll_timer_en;
    logic wut_en;
    logic lin_wake_en;
  } pmoc_pwr_s;

  typedef struct packed {
    logic prec_tick;
    logic xtal_tick;
    logic lp_tick;
  } pmoc_osc_s;
endpackage : pmoc_pkg

// File: verif/pmoc_chk_sva.sv
// checker for the power mode and calibration block
// assumes binding onto pmoc_top, single clock domain
`timescale 1ns/1ps
`include "pmoc_params.svh"
module pmoc_chk #(
  parameter int REF_W = 9,
  parameter int LP_W = 10
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic wake_event,
  input wire logic hv_prec_osc_en,
  input wire logic wut_on_lp_osc,
  input wire pmoc_pkg::pmoc_pwr_s pwr_out,
  input wire logic core_clk_tick,
  input wire logic [3:0] lp_osc_trim
);
  import pmoc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_prec_gate: assert property (pwr_out.prec_osc_en |-> $past(hv_prec_osc_en))
    else $error("precision input on without hv enable");
  a_pll_stays: assert property (pwr_out.core_en || pwr_out.periph_en |-> pwr_out.pll_en)
    else $error("pll off while core or periph on");
  a_per_stays: assert property (pwr_out.core_en |-> pwr_out.periph_en)
    else $error("periph off while core on");
  a_wake_sets: assert property (wake_event |-> ##2 pwr_out[5:3] == 3'h7)
    else $error("wake did not restore power bits");
  a_lin_alive: assert property (!$past(rst) |-> pwr_out.lin_wake_en)
    else $error("lin wake detect off");
  a_wut_follow: assert property (!$past(rst) |->
      pwr_out.wut_en == (pwr_out.periph_en | $past(wut_on_lp_osc)))
    else $error("wake timer enable wrong");
  a_timer_pll: assert property (!$past(rst) |-> pwr_out.pll_timer_en == pwr_out.pll_en)
    else $error("pll timer enable wrong");
  a_core_quiet: assert property (!pwr_out.core_en && !$past(pwr_out.core_en)
      |-> !core_clk_tick)
    else $error("core tick while core off");
  a_trim_write: assert property ($changed(lp_osc_trim)
      |-> $past(psel && penable && pwrite && paddr == `PMOC_A_TRIM))
    else $error("trim changed without write");
  c_wake: cover property (wake_event);
  c_core_off: cover property ($fell(pwr_out.core_en));
  c_trim: cover property ($changed(lp_osc_trim));
endmodule : pmoc_chk
bind pmoc_top pmoc_chk #(.REF_W(REF_W), .LP_W(LP_W)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .wake_event(wake_event), .hv_prec_osc_en(hv_prec_osc_en), .wut_on_lp_osc(wut_on_lp_osc),
  .pwr_out(pwr_out), .core_clk_tick(core_clk_tick), .lp_osc_trim(lp_osc_trim));

// File: verif/power_mode_and_osc_calibration_test.sv
// self-checking bench for the power mode and calibration block
// assumes pmoc_top and its checker are compiled first
`timescale 1ns/1ps
`include "pmoc_params.svh"
module power_mode_and_osc_calibration_test;
  import pmoc_pkg::*;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err;
  logic wake_event, hv_prec_osc_en, wut_on_lp_osc, core_clk_tick;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] lp_osc_trim;
  logic [7:0] cyc;
  pmoc_osc_s osc_in;
  pmoc_pwr_s pwr_out;
  int fail_count, total_checks, n;
  pmoc_top u_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_event(wake_event), .hv_prec_osc_en(hv_prec_osc_en),
    .wut_on_lp_osc(wut_on_lp_osc), .osc_in(osc_in), .pwr_out(pwr_out),
    .core_clk_tick(core_clk_tick), .lp_osc_trim(lp_osc_trim));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // prec and lp tick together every 2 cycles, crystal every 8
  always @(posedge clk_sys) begin
    cyc <= cyc + 8'h01;
    osc_in <= '{prec_tick: !cyc[0], xtal_tick: cyc[2:0] == 3'h0, lp_tick: !cyc[0]};
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask : rdchk
  task automatic pw(input logic [31:0] d);
    apb(1'b1, `PMOC_A_KEY0, `PMOC_KEY0_VAL);
    apb(1'b1, `PMOC_A_POWER, d);
    apb(1'b1, `PMOC_A_KEY1, `PMOC_KEY1_VAL);
    @(posedge clk_sys);
  endtask : pw
  task automatic cnt(input int cy);
    n = 0;
    repeat (cy) begin
      @(posedge clk_sys);
      if (core_clk_tick === 1'b1) n++;
    end
  endtask : cnt
  task automatic t_reset;
    rdchk("power", `PMOC_A_POWER, 32'h79);
    rdchk("calctl", `PMOC_A_CALCTL, 32'h00);
    rdchk("trim", `PMOC_A_TRIM, 32'h08);
    check("pwr bits", {pwr_out.xtal_en, pwr_out[5:3]}, 32'h7);
    check("prec on", pwr_out.prec_osc_en, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_power;
    apb(1'b1, `PMOC_A_POWER, 32'h00);
    rdchk("unkeyed", `PMOC_A_POWER, 32'h79);
    pw(32'h88);
    rdchk("core only", `PMOC_A_POWER, 32'hB8);
    check("xtal on", pwr_out.xtal_en, 1'b1);
    check("prec off", pwr_out.prec_osc_en, 1'b0);
    pw(32'h10);
    rdchk("periph only", `PMOC_A_POWER, 32'h30);
    cnt(64);
    check("core ticks", n, 32'h0);
    pw(32'h00);
    rdchk("all off", `PMOC_A_POWER, 32'h00);
    check("off bits", pwr_out[5:0], 32'h03);
    wut_on_lp_osc <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("wut off", pwr_out.wut_en, 1'b0);
    wake_event <= 1'b1;
    @(posedge clk_sys);
    wake_event <= 1'b0;
    rdchk("woken", `PMOC_A_POWER, 32'h38);
    $display("power test done");
  endtask : t_power
  task automatic t_div;
    for (int c = 0; c < 7; c++) begin
      pw(32'h38 | c);
      repeat (70) @(posedge clk_sys);
      cnt(128);
      check("div ticks", n, 128 >> c);
    end
    $display("divider test done");
  endtask : t_div
  task automatic t_cal(input logic src);
    apb(1'b1, `PMOC_A_CALCTL, {27'h0, src, 4'h1});
    repeat (20) @(posedge clk_sys);
    rdchk("counting", `PMOC_A_CALSTA, 32'h0B);
    do apb(1'b0, `PMOC_A_CALSTA, 32'h0); while (rd[0] !== 1'b0);
    rdchk("idle", `PMOC_A_CALSTA, 32'h00);
    rdchk("ref end", `PMOC_A_REFCNT, 32'h1FF);
    apb(1'b0, `PMOC_A_LPCNT, 32'h0);
    check("lp match", rd >= 510 && rd <= 512, 1'b1);
    rdchk("en clear", `PMOC_A_CALCTL, {27'h0, src, 4'h0});
    repeat (40) @(posedge clk_sys);
    rdchk("ref hold", `PMOC_A_REFCNT, 32'h1FF);
    $display("calibration test done");
  endtask : t_cal
  task automatic t_abort;
    logic [31:0] r;
    apb(1'b1, `PMOC_A_CALCTL, 32'h01);
    repeat (100) @(posedge clk_sys);
    apb(1'b1, `PMOC_A_CALCTL, 32'h00);
    rdchk("aborted", `PMOC_A_CALSTA, 32'h00);
    apb(1'b0, `PMOC_A_REFCNT, 32'h0);
    r = rd;
    apb(1'b1, `PMOC_A_CALCTL, 32'h04);
    rdchk("lp clr", `PMOC_A_LPCNT, 32'h0);
    rdchk("ref kept", `PMOC_A_REFCNT, r);
    apb(1'b1, `PMOC_A_CALCTL, 32'h02);
    rdchk("ref clr", `PMOC_A_REFCNT, 32'h0);
    apb(1'b1, `PMOC_A_CALCTL, 32'h01);
    repeat (100) @(posedge clk_sys);
    apb(1'b1, `PMOC_A_CALCTL, 32'h08);
    rdchk("rst idle", `PMOC_A_CALSTA, 32'h00);
    rdchk("rst ref", `PMOC_A_REFCNT, 32'h0);
    rdchk("rst lp", `PMOC_A_LPCNT, 32'h0);
    $display("abort test done");
  endtask : t_abort
  task automatic t_regs;
    apb(1'b1, `PMOC_A_TRIM, 32'hA5);
    rdchk("trim rd", `PMOC_A_TRIM, 32'h05);
    check("trim out", lp_osc_trim, 4'h5);
    apb(1'b0, 32'hFFFF0400, 32'h0);
    check("unmapped", err, 1'b1);
    $display("register test done");
  endtask : t_regs
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  initial begin
    #4000000;
    fail_count++;
    $display("watchdog expired");
    complete_run;
  end
  initial begin
    {rst, hv_prec_osc_en, wut_on_lp_osc} = 3'h7;
    {psel, penable, pwrite, wake_event, paddr, pwdata} = '0;
    {cyc, osc_in, fail_count, total_checks} = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_reset;
    t_power;
    t_div;
    t_cal(1'b0);
    t_cal(1'b1);
    t_abort;
    t_regs;
    complete_run;
  end
endmodule : power_mode_and_osc_calibration_test
